//--- msi_exposure_ctrl.sv
`timescale 1ns/1ns
module msi_exposure_ctrl
  import msi_pkg::*;
(
  input  wire logic             mclk_in,
  input  wire logic             nrst_in,
  input  wire logic             wb_cyc_in,
  input  wire logic             wb_stb_in,
  input  wire logic             wb_we_in,
  input  wire logic [7:0]       wb_adr_in,
  input  wire logic [3:0]       wb_sel_in,
  input  wire logic [31:0]      wb_dat_in,
  output logic [31:0]           wb_dat_out,
  output logic                  wb_ack_out,
  input  wire logic             pix_valid_in,
  input  wire logic             pix_first_in,
  input  wire logic [PIX_W-1:0] pix_raw_in,
  output logic                  full_reset_out,
  output logic                  recharge_out,
  output logic [1:0]            reset_level_out,
  output logic                  int_active_out,
  output logic                  convert_out,
  output logic                  frame_busy_out,
  output logic                  sample_valid_out,
  output logic [PIX_W-1:0]      sample_out
);

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // bit 2 set means no set mask bit at or above from
  function automatic logic [2:0] next_slot(input logic [3:0] mask, input logic [2:0] from);
    logic [2:0] r;
    r = 3'b100;
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (mask[i] && (3'(i) >= from)) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  logic [31:0]      slot_r [0:NUM_SLOTS-1], slot_nxt [0:NUM_SLOTS-1];
  logic [31:0]      cyc_r  [0:NUM_SLOTS-1], cyc_nxt  [0:NUM_SLOTS-1];
  logic             rolling_r, rolling_nxt, map_en_r, map_en_nxt, refused_r, refused_nxt, v1_r, v1_nxt;
  logic [1:0]       tbl_sel_r, tbl_sel_nxt, map_tbl_r, map_tbl_nxt, cur_slot_r, cur_slot_nxt;
  logic [10:0]      col_lo_r, col_lo_nxt, col_hi_r, col_hi_nxt;
  logic [10:0]      row_lo_r, row_lo_nxt, row_hi_r, row_hi_nxt;
  logic [10:0]      pcol, prow, col_r, col_nxt, row_r, row_nxt;
  logic [9:0]       map_idx_r, map_idx_nxt;
  logic             map_we, wb_ack_nxt, req, wr_stb, start, tmr_load, tmr_done, in_roi;
  logic [31:0]      wb_dat_nxt, tmr_cycles, int_len_r, int_len_nxt;
  logic [7:0]       adr_w;
  msi_state_t       state_r, state_nxt;
  logic [3:0]       mask_r, mask_nxt, live_mask;
  logic [2:0]       first_slot, follow_slot;
  logic [PIX_W-1:0] inv_r, inv_nxt;
  assign req        = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr_stb     = req && wb_we_in;
  assign adr_w      = {wb_adr_in[7:2], 2'b00};
  assign start      = wr_stb && (adr_w == ADR_CTRL) && wb_sel_in[0] && wb_dat_in[CTRL_START];
  assign map_we     = wr_stb && (adr_w == ADR_MAP_DAT) && wb_sel_in[0];
  assign live_mask  = {slot_r[3] != SLOT_RST, slot_r[2] != SLOT_RST, slot_r[1] != SLOT_RST, slot_r[0] != SLOT_RST};
  assign first_slot  = next_slot(live_mask, 3'b000);
  assign follow_slot = next_slot(mask_r, 3'({1'b0, cur_slot_r}) + 3'b001);
  // register file; slots are taken as whole nanosecond counts
  always_comb begin
    for (int i = 0; i < NUM_SLOTS; i++) begin
      slot_nxt[i] = slot_r[i];
    end
    rolling_nxt = rolling_r;
    map_en_nxt  = map_en_r;
    tbl_sel_nxt = tbl_sel_r;
    col_lo_nxt  = col_lo_r;
    col_hi_nxt  = col_hi_r;
    row_lo_nxt  = row_lo_r;
    row_hi_nxt  = row_hi_r;
    map_tbl_nxt = map_tbl_r;
    map_idx_nxt = map_idx_r;
    wb_ack_nxt  = req;
    wb_dat_nxt  = 32'h0000_0000;
    if (wr_stb) begin
      if (adr_w <= ADR_SLOT3) begin
        slot_nxt[adr_w[3:2]] = lane_merge(slot_r[adr_w[3:2]], wb_dat_in, wb_sel_in);
      end
      if (adr_w == ADR_CTRL && wb_sel_in[0]) begin
        rolling_nxt = wb_dat_in[CTRL_ROLLING];
        tbl_sel_nxt = wb_dat_in[CTRL_TBL_LO +: 2];
        map_en_nxt  = wb_dat_in[CTRL_MAP_EN];
      end
      if (adr_w == ADR_ROI_COL) begin
        col_lo_nxt = wb_dat_in[10:0];
        col_hi_nxt = wb_dat_in[ROI_HI_LO +: 11];
      end
      if (adr_w == ADR_ROI_ROW) begin
        row_lo_nxt = wb_dat_in[10:0];
        row_hi_nxt = wb_dat_in[ROI_HI_LO +: 11];
      end
      if (adr_w == ADR_MAP_ADR) begin
        map_idx_nxt = wb_dat_in[9:0];
        map_tbl_nxt = wb_dat_in[MAP_TBL_LO +: 2];
      end
      if (map_we) begin
        map_idx_nxt = map_idx_r + 10'h001;
      end
    end else if (req) begin
      if (adr_w <= ADR_SLOT3) begin
        wb_dat_nxt = slot_r[adr_w[3:2]];
      end else begin
        case (adr_w)
          ADR_CTRL: begin
            wb_dat_nxt[CTRL_ROLLING]     = rolling_r;
            wb_dat_nxt[CTRL_TBL_LO +: 2] = tbl_sel_r;
            wb_dat_nxt[CTRL_MAP_EN]      = map_en_r;
          end
          ADR_STATUS: begin
            wb_dat_nxt[STAT_BUSY]         = state_r != ST_IDLE;
            wb_dat_nxt[STAT_REFUSED]      = refused_r;
            wb_dat_nxt[STAT_INTEG]        = state_r == ST_INTEG;
            wb_dat_nxt[STAT_SLOT_LO +: 2] = cur_slot_r;
            wb_dat_nxt[STAT_MASK_LO +: 4] = mask_r;
          end
          ADR_ROI_COL: wb_dat_nxt = {5'h00, col_hi_r, 5'h00, col_lo_r};
          ADR_ROI_ROW: wb_dat_nxt = {5'h00, row_hi_r, 5'h00, row_lo_r};
          ADR_MAP_ADR: wb_dat_nxt = {20'h0_0000, map_tbl_r, map_idx_r};
          default:     wb_dat_nxt = 32'h0000_0000;
        endcase
      end
    end
  end
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        slot_r[i] <= SLOT_RST;
      end
      rolling_r  <= 1'b0;
      map_en_r   <= 1'b0;
      tbl_sel_r  <= 2'h0;
      col_lo_r   <= ROI_LO_RST;
      col_hi_r   <= COL_HI_RST;
      row_lo_r   <= ROI_LO_RST;
      row_hi_r   <= ROW_HI_RST;
      map_tbl_r  <= 2'h0;
      map_idx_r  <= 10'h000;
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        slot_r[i] <= slot_nxt[i];
      end
      rolling_r  <= rolling_nxt;
      map_en_r   <= map_en_nxt;
      tbl_sel_r  <= tbl_sel_nxt;
      col_lo_r   <= col_lo_nxt;
      col_hi_r   <= col_hi_nxt;
      row_lo_r   <= row_lo_nxt;
      row_hi_r   <= row_hi_nxt;
      map_tbl_r  <= map_tbl_nxt;
      map_idx_r  <= map_idx_nxt;
      wb_ack_out <= wb_ack_nxt;
      wb_dat_out <= wb_dat_nxt;
    end
  end
  // exposure sequencer; slot values are frozen at start so writes mid-frame wait
  always_comb begin
    state_nxt    = state_r;
    cur_slot_nxt = cur_slot_r;
    mask_nxt     = mask_r;
    refused_nxt  = refused_r;
    tmr_load     = 1'b0;
    tmr_cycles   = cyc_r[cur_slot_r];
    int_len_nxt  = (state_r == ST_INTEG) ? int_len_r + 32'h0000_0001 : 32'h0000_0000;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      cyc_nxt[i] = cyc_r[i];
    end
    case (state_r)
      ST_IDLE: begin
        if (start) begin
          refused_nxt = (live_mask == 4'h0) || (rolling_nxt && ((live_mask & (live_mask - 4'h1)) != 4'h0));
          if (!first_slot[2]) begin
            state_nxt    = ST_FRESET;
            cur_slot_nxt = first_slot[1:0];
            mask_nxt     = rolling_nxt ? (4'h1 << first_slot[1:0]) : live_mask;
            for (int i = 0; i < NUM_SLOTS; i++) begin
              cyc_nxt[i] = ns_to_cycles(slot_r[i]);
            end
          end
        end
      end
      ST_FRESET, ST_RECHARGE: begin
        tmr_load  = 1'b1;
        state_nxt = ST_INTEG;
      end
      ST_INTEG: begin
        if (tmr_done) begin
          if (follow_slot[2]) begin
            state_nxt = ST_CONVERT;
          end else begin
            state_nxt    = ST_RECHARGE;
            cur_slot_nxt = follow_slot[1:0];
          end
        end
      end
      ST_CONVERT: state_nxt = ST_IDLE;
      default:    state_nxt = ST_IDLE;
    endcase
  end
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r    <= ST_IDLE;
      int_len_r  <= 32'h0000_0000;
      cur_slot_r <= 2'h0;
      mask_r     <= 4'h0;
      refused_r  <= 1'b0;
      for (int i = 0; i < NUM_SLOTS; i++) begin
        cyc_r[i] <= 32'h0000_0001;
      end
    end else begin
      state_r    <= state_nxt;
      int_len_r  <= int_len_nxt;
      cur_slot_r <= cur_slot_nxt;
      mask_r     <= mask_nxt;
      refused_r  <= refused_nxt;
      for (int i = 0; i < NUM_SLOTS; i++) begin
        cyc_r[i] <= cyc_nxt[i];
      end
    end
  end

  msi_period_timer u_timer (.mclk_in(mclk_in), .nrst_in(nrst_in), .load_in(tmr_load), .cycles_in(tmr_cycles),
    .done_out(tmr_done));
  assign reset_level_out = cur_slot_r;
  assign full_reset_out  = state_r == ST_FRESET;
  assign recharge_out    = state_r == ST_RECHARGE;
  assign convert_out     = state_r == ST_CONVERT;
  assign int_active_out  = state_r == ST_INTEG;
  assign frame_busy_out  = state_r != ST_IDLE;
  // readout position; the first flag realigns to the frame origin
  always_comb begin
    pcol    = pix_first_in ? 11'h000 : col_r;
    prow    = pix_first_in ? 11'h000 : row_r;
    col_nxt = col_r;
    row_nxt = row_r;
    in_roi  = (pcol >= col_lo_r) && (pcol <= col_hi_r) && (prow >= row_lo_r) && (prow <= row_hi_r);
    v1_nxt  = pix_valid_in && in_roi;
    inv_nxt = ~pix_raw_in;
    if (pix_valid_in) begin
      col_nxt = (pcol == 11'(FRAME_COLS - 1)) ? 11'h000 : pcol + 11'h001;
      row_nxt = prow;
      if (pcol == 11'(FRAME_COLS - 1)) begin
        row_nxt = (prow == 11'(FRAME_ROWS - 1)) ? 11'h000 : prow + 11'h001;
      end
    end
  end
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      col_r <= 11'h000;
      row_r <= 11'h000;
      v1_r  <= 1'b0;
      inv_r <= '0;
    end else begin
      col_r <= col_nxt;
      row_r <= row_nxt;
      v1_r  <= v1_nxt;
      inv_r <= inv_nxt;
    end
  end

  msi_value_map u_map (.mclk_in(mclk_in), .nrst_in(nrst_in), .wr_en_in(map_we), .wr_tbl_in(map_tbl_r),
    .wr_idx_in(map_idx_r), .wr_val_in(wb_dat_in[PIX_W-1:0]), .sel_tbl_in(tbl_sel_r), .map_en_in(map_en_r),
    .in_valid_in(v1_r), .in_data_in(inv_r), .out_valid_out(sample_valid_out), .out_data_out(sample_out));

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  a_skip_zero_slot: assert property (state_r == ST_INTEG |-> mask_r[cur_slot_r])
    else $error("integration running on a skipped slot");
  a_slot_order_up: assert property (state_r == ST_RECHARGE |-> cur_slot_r > $past(cur_slot_r))
    else $error("periods not in rising slot order");
  a_level_tracks_slot: assert property (int_active_out |-> mask_r[reset_level_out] && $stable(reset_level_out))
    else $error("reset level changed inside a period");
  a_recharge_between: assert property (recharge_out |-> $past(int_active_out) ##1 int_active_out)
    else $error("recharge outside the gap between periods");
  a_convert_after_last: assert property (convert_out |-> $past(tmr_done) ##1 !frame_busy_out)
    else $error("conversion not right after the last period");
  a_rolling_single: assert property (state_r == ST_FRESET && rolling_r |-> $onehot(mask_r))
    else $error("rolling shutter frame with several periods");
  a_period_length: assert property (int_active_out && tmr_done |-> int_len_r + 32'h0000_0001 == cyc_r[cur_slot_r])
    else $error("period length differs from programmed count");
  a_map_latency: assert property (v1_r |-> ##MAP_LAT_CYC sample_valid_out)
    else $error("table latency not constant");
  a_roi_gate: assert property (sample_valid_out |-> $past(v1_r))
    else $error("sample outside the selected region");
  a_multi_slope_many: assert property (state_r == ST_RECHARGE |-> !rolling_r || !$past(rolling_r, 2))
    else $error("extra period taken in rolling shutter mode");
  c_four_periods: cover property (state_r == ST_RECHARGE && cur_slot_r == 2'h3 && mask_r == 4'hF);
  c_single_period: cover property (convert_out && $onehot(mask_r));
  c_refused_start: cover property (start && !frame_busy_out ##1 refused_r);
  c_mapped_sample: cover property (sample_valid_out && map_en_r);

endmodule

//--- msi_pkg.sv
package msi_pkg;

  // clock and conversion timing
  localparam int CLK_NS      = 40;
  localparam int MAP_LAT_NS  = 12;
  // least latency rounds up to whole cycles
  localparam int MAP_LAT_CYC = (MAP_LAT_NS + CLK_NS - 1) / CLK_NS;

  // frame geometry and sample width
  localparam int PIX_W       = 10;
  localparam int POS_W       = 11;
  localparam int FRAME_COLS  = 1280;
  localparam int FRAME_ROWS  = 1024;
  localparam int NUM_SLOTS   = 4;
  localparam int MAP_TABLES  = 3;
  localparam int MAP_DEPTH   = 1024;

  // register byte offsets
  localparam logic [7:0] ADR_SLOT0   = 8'h00;
  localparam logic [7:0] ADR_SLOT3   = 8'h0C;
  localparam logic [7:0] ADR_CTRL    = 8'h10;
  localparam logic [7:0] ADR_STATUS  = 8'h14;
  localparam logic [7:0] ADR_ROI_COL = 8'h18;
  localparam logic [7:0] ADR_ROI_ROW = 8'h1C;
  localparam logic [7:0] ADR_MAP_ADR = 8'h20;
  localparam logic [7:0] ADR_MAP_DAT = 8'h24;

  // control fields
  localparam int CTRL_START   = 0;
  localparam int CTRL_ROLLING = 1;
  localparam int CTRL_TBL_LO  = 2;
  localparam int CTRL_MAP_EN  = 4;

  // status fields
  localparam int STAT_BUSY    = 0;
  localparam int STAT_REFUSED = 1;
  localparam int STAT_INTEG   = 2;
  localparam int STAT_SLOT_LO = 3;
  localparam int STAT_MASK_LO = 8;

  // region and table address fields
  localparam int ROI_HI_LO    = 16;
  localparam int MAP_TBL_LO   = 10;

  // reset values
  localparam logic [31:0] SLOT_RST    = 32'h0000_0000;
  localparam logic [10:0] ROI_LO_RST  = 11'h000;
  localparam logic [10:0] COL_HI_RST  = 11'h4FF;
  localparam logic [10:0] ROW_HI_RST  = 11'h3FF;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_FRESET   = 3'b001,
    ST_INTEG    = 3'b010,
    ST_RECHARGE = 3'b011,
    ST_CONVERT  = 3'b100
  } msi_state_t;

  // nanoseconds to cycles, rounded to nearest, never below one cycle
  function automatic logic [31:0] ns_to_cycles(input logic [31:0] ns);
    logic [32:0] t;
    t = ({1'b0, ns} + 33'(CLK_NS / 2)) / 33'(CLK_NS);
    if (t == 33'h0_0000_0000) begin
      t = 33'h0_0000_0001;
    end
    return t[31:0];
  endfunction

endpackage

//--- msi_period_timer.sv
`timescale 1ns/1ns
module msi_period_timer
  import msi_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  input  wire logic        load_in,
  input  wire logic [31:0] cycles_in,
  output logic             done_out
);

  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        run_r;
  logic        run_nxt;

  // done marks the last cycle of the loaded count
  assign done_out = run_r && (cnt_r == 32'h0000_0001);

  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    if (load_in) begin
      cnt_nxt = cycles_in;
      run_nxt = 1'b1;
    end else if (run_r) begin
      cnt_nxt = cnt_r - 32'h0000_0001;
      run_nxt = !done_out;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_r <= 32'h0000_0000;
      run_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
    end
  end

endmodule

//--- msi_value_map.sv
`timescale 1ns/1ns
module msi_value_map
  import msi_pkg::*;
(
  input  wire logic             mclk_in,
  input  wire logic             nrst_in,
  input  wire logic             wr_en_in,
  input  wire logic [1:0]       wr_tbl_in,
  input  wire logic [9:0]       wr_idx_in,
  input  wire logic [PIX_W-1:0] wr_val_in,
  input  wire logic [1:0]       sel_tbl_in,
  input  wire logic             map_en_in,
  input  wire logic             in_valid_in,
  input  wire logic [PIX_W-1:0] in_data_in,
  output logic                  out_valid_out,
  output logic [PIX_W-1:0]      out_data_out
);

  logic [PIX_W-1:0] table_mem [0:MAP_TABLES*MAP_DEPTH-1];
  logic [PIX_W-1:0] data_nxt;
  logic             valid_nxt;

  // single-stage lookup
  // a fourth table code or a disabled map passes samples through unchanged
  always_comb begin
    valid_nxt = in_valid_in;
    data_nxt  = in_data_in;
    if (map_en_in && (sel_tbl_in < 2'(MAP_TABLES))) begin
      data_nxt = table_mem[{sel_tbl_in, in_data_in}];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (wr_en_in && (wr_tbl_in < 2'(MAP_TABLES))) begin
      table_mem[{wr_tbl_in, wr_idx_in}] <= wr_val_in;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
    end else begin
      out_valid_out <= valid_nxt;
      out_data_out  <= data_nxt;
    end
  end

endmodule

//--- msi_sensor_model.sv
`timescale 1ns/1ns
module msi_sensor_model
  import msi_pkg::*;
#(
  parameter int NPIX = 4
)
(
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  input  wire logic        convert_in,
  output logic             pix_valid_out,
  output logic             pix_first_out,
  output logic [PIX_W-1:0] pix_raw_out
);
  logic             run_r, run_nxt;
  logic [7:0]       idx_r, idx_nxt;
  logic             valid_nxt, first_nxt;
  logic [PIX_W-1:0] raw_nxt;

  always_comb begin
    run_nxt   = run_r;
    idx_nxt   = idx_r;
    valid_nxt = 1'b0;
    first_nxt = 1'b0;
    // idle data line keeps toggling so a stale value never passes
    raw_nxt   = ~pix_raw_out;
    if (convert_in) begin
      run_nxt = 1'b1;
      idx_nxt = 8'h00;
    end else if (run_r) begin
      valid_nxt = 1'b1;
      first_nxt = (idx_r == 8'h00);
      raw_nxt   = PIX_W'(idx_r);
      idx_nxt   = idx_r + 8'h01;
      if (32'(idx_r) == NPIX - 1) begin
        run_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_r         <= 1'b0;
      idx_r         <= 8'h00;
      pix_valid_out <= 1'b0;
      pix_first_out <= 1'b0;
      pix_raw_out   <= 10'h000;
    end else begin
      run_r         <= run_nxt;
      idx_r         <= idx_nxt;
      pix_valid_out <= valid_nxt;
      pix_first_out <= first_nxt;
      pix_raw_out   <= raw_nxt;
    end
  end
endmodule

//--- testbench.sv
`timescale 1ns/1ns
module testbench;
  import msi_pkg::*;
  logic             mclk_in = 1'b0;
  logic             nrst_in = 1'b0;
  logic             cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]       sel = 4'h0, bsel = 4'hF;
  logic [7:0]       adr = 8'h00;
  logic [31:0]      wdat = 32'h0000_0000, rdat, wb_dat_out;
  logic             wb_ack_out, pv, pf, full_rst, rchg, integ, conv, busy, sv;
  logic [PIX_W-1:0] raw, smp;
  logic [1:0]       lvl;
  logic [31:0]      lvl_q[$], len_q[$], smp_q[$];
  int               run_len = 0, cycles = 0, err_count = 0, total_checks = 0, roi_lo, roi_hi;

  always #20 mclk_in = ~mclk_in;

  msi_exposure_ctrl i_msi_exposure_ctrl (.mclk_in(mclk_in), .nrst_in(nrst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .pix_valid_in(pv), .pix_first_in(pf), .pix_raw_in(raw), .full_reset_out(full_rst),
    .recharge_out(rchg), .reset_level_out(lvl), .int_active_out(integ), .convert_out(conv),
    .frame_busy_out(busy), .sample_valid_out(sv), .sample_out(smp));

  msi_sensor_model #(.NPIX(4)) i_msi_sensor_model (.mclk_in(mclk_in), .nrst_in(nrst_in), .convert_in(conv),
    .pix_valid_out(pv), .pix_first_out(pf), .pix_raw_out(raw));

  // registered outputs sampled at the edge see the settled value of the cycle before
  always @(posedge mclk_in) begin
    cycles++;
    if (integ === 1'b1) run_len++;
    if (full_rst === 1'b1 || rchg === 1'b1) lvl_q.push_back(32'(lvl));
    if ((rchg === 1'b1 || conv === 1'b1) && run_len > 0) begin
      len_q.push_back(32'(run_len));
      run_len = 0;
    end
    if (sv === 1'b1) smp_q.push_back(32'(smp));
    if (cycles == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_in);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= bsel;
    do begin
      @(posedge mclk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 50);
    rdat = wb_dat_out;
    chk(32'(n < 50), 32'h0000_0001, "bus answer");
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0; sel <= 4'h0;
  endtask

  task automatic frame(input int s0, input int s1, input int s2, input int s3, input logic roll,
                       input logic [1:0] tbl);
    int s[4], el[$], ep[$], nz, n;
    logic [31:0] ex[$];
    s = '{s0, s1, s2, s3};
    nz = 0;
    n = 0;
    lvl_q.delete(); len_q.delete(); smp_q.delete();
    foreach (s[i]) begin
      wb(1'b1, 8'(4 * i), 32'(s[i]));
      if (s[i] != 0) nz++;
      if (s[i] != 0 && !(roll && el.size() > 0)) begin
        el.push_back(i);
        ep.push_back(s[i] < 20 ? 1 : (s[i] + 20) / 40);
      end
    end
    wb(1'b1, ADR_CTRL, {27'h000_0000, tbl != 2'd3, tbl, roll, 1'b1});
    while (busy !== 1'b0 && n < 5000) begin
      @(posedge mclk_in);
      n++;
    end
    chk(32'(n < 5000), 32'h0000_0001, "frame end");
    repeat (10) @(posedge mclk_in);
    wb(1'b0, ADR_STATUS, 32'h0000_0000);
    chk(32'(rdat[STAT_REFUSED]), 32'(nz == 0 || (roll && nz > 1)), "refused flag");
    chk(32'(lvl_q.size()), 32'(el.size()), "period count");
    foreach (el[i]) begin
      chk(lvl_q[i], 32'(el[i]), "reset level order");
      chk(len_q[i], 32'(ep[i]), "period length");
    end
    for (int k = roi_lo; k <= roi_hi && k < 4 && nz > 0; k++) begin
      ex.push_back(tbl == 2'd3 ? 32'(10'h3FF - 10'(k)) : 32'(tbl * 64 + 3 - k));
    end
    chk(32'(smp_q.size()), 32'(ex.size()), "sample count");
    foreach (ex[i]) chk(smp_q[i], ex[i], "sample value");
    $display("test done: slots %0d %0d %0d %0d rolling %0d table %0d", s0, s1, s2, s3, roll, tbl);
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge mclk_in);
    nrst_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, 8'(4 * i), 32'h0000_0000);
      chk(rdat, SLOT_RST, "slot reset");
    end
    wb(1'b0, ADR_ROI_COL, 32'h0000_0000);
    chk(rdat, {5'h00, COL_HI_RST, 5'h00, ROI_LO_RST}, "column region reset");
    wb(1'b0, ADR_ROI_ROW, 32'h0000_0000);
    chk(rdat, {5'h00, ROW_HI_RST, 5'h00, ROI_LO_RST}, "row region reset");
    wb(1'b1, 8'h28, 32'hFFFF_FFFF);
    wb(1'b0, 8'h28, 32'h0000_0000);
    chk(rdat, 32'h0000_0000, "unmapped read");
    wb(1'b1, ADR_SLOT0, 32'h0000_00C8);
    wb(1'b0, ADR_SLOT0, 32'h0000_0000);
    chk(rdat, 32'h0000_00C8, "slot readback");
    bsel = 4'h1;
    wb(1'b1, 8'h04, 32'hFFFF_FF2A);
    bsel = 4'hF;
    wb(1'b0, 8'h04, 32'h0000_0000);
    chk(rdat, 32'h0000_002A, "slot byte lane");
    $display("test done: register reset values");
    roi_lo = 0;
    roi_hi = 1279;
    frame(0, 0, 200, 40, 1'b0, 2'd3);
    frame(10, 0, 0, 0, 1'b0, 2'd3);
    frame(60, 100, 140, 19, 1'b0, 2'd3);
    frame(0, 0, 0, 0, 1'b0, 2'd3);
    frame(80, 0, 40, 0, 1'b1, 2'd3);
    roi_lo = 1;
    roi_hi = 2;
    wb(1'b1, ADR_ROI_COL, {5'h00, 11'h002, 5'h00, 11'h001});
    for (int t = 0; t < 3; t++) begin
      wb(1'b1, ADR_MAP_ADR, {20'h0_0000, 2'(t), 10'h3FC});
      for (int j = 0; j < 4; j++) wb(1'b1, ADR_MAP_DAT, 32'(t * 64 + j));
      frame(0, 0, 0, 40, 1'b0, 2'(t));
    end
    end_of_test();
  end
endmodule
